// ### rtl/rio_ind.sv
`timescale 1ns/100ps

// Contract
// - unit-ready lamp lit only with power and host recognition of the unit
// - input-mode lamp lit for one input word, dark for two words
// - output-mode lamp lit for one output word, dark for two words
// - master transmission-ready lamp lit while powered and transmitting, off on error
// - master hold lamp lit when inputs are retained on transmission error
// - master transmitting lamp blinks searching or transmitting, on for error, off on fault
// - master terminator lamp on at power-up, off after one terminator, blinks for several
// - slave_address_error_lamp-error lamp steady for slave address 28 to 30, blinks for other address errors
// - slave-alarm lamp lights after an output slave error and stays on
// - alarm keeps one bit only, no address, bit or fault kind
// - expansion unit-number lamp lit as second unit, dark as first
// - expansion transmitting lamp blinks transmitting, on for error, off on fault
// - on transmission error inputs to host are held or cleared per hold setting
// - second expansion unit treats a 4-point slave as an address error
module rio_ind #(
	parameter int unsigned BLINK_HALF_CYC = rio_pkg::BLINK_HALF_CYC
) (
	// clock and reset
	input  wire logic                   mclk_in,
	input  wire logic                   resetn_in,
	// register port
	input  wire logic [7:0]             reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [31:0]            reg_rdata_out,
	// unit state
	input  wire logic                   power_good_in,
	input  wire logic                   host_recognised_in,
	input  wire logic                   tx_active_in,
	input  wire logic                   tx_error_in,
	input  wire logic                   unit_fault_in,
	input  wire logic                   term_single_in,
	input  wire logic                   term_multi_in,
	// slave reports
	input  wire rio_pkg::rio_slave_t    slave_in,
	input  wire logic                   slave_alarm_in,
	// input data toward the host
	input  wire logic                   in_word_valid_in,
	input  wire logic [31:0]            in_word_in,
	output logic      [31:0]            host_in_word_out,
	// lamps and interrupt
	output rio_pkg::rio_lamps_t         lamps_out,
	output logic                        irq_out
);

	////////////////////////////////////////////////////////////////////////////
	// functions
	function automatic logic is_fixed_addr(input logic [4:0] addr);
		is_fixed_addr = (addr >= rio_pkg::SLAVE_ADDRESS_ERROR_LAMP_FIXED_LO) && (addr <= rio_pkg::SLAVE_ADDRESS_ERROR_LAMP_FIXED_HI);
	endfunction : is_fixed_addr

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offs);
		reg_hit = (addr == offs);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////////
	// reset release
	logic                     rst_meta;
	logic                     rstn;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta <= 1'b0;
			rstn     <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rstn     <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	rio_pkg::rio_cfg_t        cfg;
	logic [3:0]               irq_status;
	logic [3:0]               irq_mask;
	logic [3:0]               irq_set;
	logic [3:0]               next_irq_status;
	logic                     wr_cfg;
	logic                     wr_irq_clr;
	logic                     wr_mask;

	assign wr_cfg     = reg_wr_in && reg_hit(reg_addr_in, rio_pkg::REG_CONFIG);
	assign wr_irq_clr = reg_wr_in && reg_hit(reg_addr_in, rio_pkg::REG_IRQ_STATUS);
	assign wr_mask    = reg_wr_in && reg_hit(reg_addr_in, rio_pkg::REG_IRQ_MASK);

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			cfg      <= rio_pkg::CONFIG_RESET;
			irq_mask <= rio_pkg::IRQ_MASK_RESET;
		end else begin
			if (wr_cfg) begin
				cfg <= reg_wdata_in[4:0];
			end
			if (wr_mask) begin
				irq_mask <= reg_wdata_in[3:0];
			end
		end
	end

	// a set in the same cycle as a clear wins
	always_comb begin
		next_irq_status = irq_status;
		if (wr_irq_clr) begin
			next_irq_status = irq_status & ~reg_wdata_in[3:0];
		end
		next_irq_status = next_irq_status | irq_set;
	end

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			irq_status <= 4'h0;
			irq_out    <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_out    <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// common blink phase
	logic [22:0]              blink_cnt;
	logic                     blink_phase;

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			blink_cnt   <= 23'h00_0000;
			blink_phase <= 1'b0;
		end else if (blink_cnt == 23'(BLINK_HALF_CYC - 1)) begin
			blink_cnt   <= 23'h00_0000;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 23'h00_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// terminator search
	rio_pkg::rio_term_t       term;
	rio_pkg::rio_term_t       next_term;

	always_comb begin
		next_term = term;
		case (term)
			rio_pkg::TERM_SEARCH: begin
				if (term_multi_in) begin
					next_term = rio_pkg::TERM_MULTI;
				end else if (term_single_in) begin
					next_term = rio_pkg::TERM_FOUND;
				end
			end
			rio_pkg::TERM_FOUND: begin
				if (term_multi_in) begin
					next_term = rio_pkg::TERM_MULTI;
				end
			end
			rio_pkg::TERM_MULTI: begin
				next_term = rio_pkg::TERM_MULTI;
			end
			default: begin
				next_term = rio_pkg::TERM_SEARCH;
			end
		endcase
		if (!power_good_in) begin
			next_term = rio_pkg::TERM_SEARCH;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			term <= rio_pkg::TERM_SEARCH;
		end else begin
			term <= next_term;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slave_address_error_lamp errors and slave alarm
	logic                     slave_address_error_lamp_fixed;
	logic                     slave_address_error_lamp_flash;
	logic                     alarm;
	logic                     hit_fixed;
	logic                     hit_other;
	logic                     tx_error_q;

	assign hit_fixed = slave_in.valid && is_fixed_addr(slave_in.addr);
	assign hit_other = slave_in.valid && !is_fixed_addr(slave_in.addr)
		&& (slave_in.other_error
		|| (cfg.expansion && cfg.unit2 && slave_in.points == rio_pkg::PTS_4));

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			slave_address_error_lamp_fixed <= 1'b0;
			slave_address_error_lamp_flash <= 1'b0;
		end else if (!power_good_in) begin
			slave_address_error_lamp_fixed <= 1'b0;
			slave_address_error_lamp_flash <= 1'b0;
		end else begin
			slave_address_error_lamp_fixed <= slave_address_error_lamp_fixed | hit_fixed;
			slave_address_error_lamp_flash <= slave_address_error_lamp_flash | hit_other;
		end
	end

	// single sticky bit, nothing about which slave or fault kind
	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			alarm <= 1'b0;
		end else begin
			alarm <= alarm | slave_alarm_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			tx_error_q <= 1'b0;
		end else begin
			tx_error_q <= tx_error_in;
		end
	end

	assign irq_set[rio_pkg::IRQ_TXERR] = tx_error_in && !tx_error_q;
	assign irq_set[rio_pkg::IRQ_ALARM] = slave_alarm_in && !alarm;
	assign irq_set[rio_pkg::IRQ_SLAVE_ADDRESS_ERROR_LAMP]  = hit_fixed || hit_other;
	assign irq_set[rio_pkg::IRQ_MULTI] = (next_term == rio_pkg::TERM_MULTI)
		&& (term != rio_pkg::TERM_MULTI);

	////////////////////////////////////////////////////////////////////////////
	// input data toward the host

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			host_in_word_out <= 32'h0000_0000;
		end else if (tx_error_in) begin
			if (!cfg.hold) begin
				host_in_word_out <= 32'h0000_0000;
			end
		end else if (in_word_valid_in) begin
			host_in_word_out <= cfg.in_single ? {16'h0000, in_word_in[15:0]} : in_word_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lamps
	rio_pkg::rio_lamps_t      next_lamps;

	always_comb begin
		next_lamps                          = '0;
		next_lamps.unit_ready_lamp          = power_good_in && host_recognised_in;
		next_lamps.input_single_word_lamp   = power_good_in && cfg.in_single;
		next_lamps.output_single_word_lamp  = power_good_in && cfg.out_single;
		next_lamps.hold_lamp                = power_good_in && cfg.hold && !cfg.expansion;
		next_lamps.unit_number_lamp         = power_good_in && cfg.expansion && cfg.unit2;
		next_lamps.tx_ready_lamp            = power_good_in && !cfg.expansion && tx_active_in
			&& !tx_error_in;
		if (!power_good_in || unit_fault_in) begin
			next_lamps.transmitting_lamp = 1'b0;
		end else if (tx_error_in) begin
			next_lamps.transmitting_lamp = 1'b1;
		end else if (tx_active_in || (!cfg.expansion && term == rio_pkg::TERM_SEARCH)) begin
			next_lamps.transmitting_lamp = blink_phase;
		end
		if (power_good_in && !cfg.expansion) begin
			case (term)
				rio_pkg::TERM_SEARCH: next_lamps.terminator_lamp = 1'b1;
				rio_pkg::TERM_MULTI:  next_lamps.terminator_lamp = blink_phase;
				default:              next_lamps.terminator_lamp = 1'b0;
			endcase
		end
		next_lamps.slave_address_error_lamp = slave_address_error_lamp_fixed ? 1'b1 : (slave_address_error_lamp_flash && blink_phase);
		next_lamps.slave_output_alarm_lamp  = power_good_in && alarm;
	end

	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			lamps_out <= '0;
		end else begin
			lamps_out <= next_lamps;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port
	always_ff @(posedge mclk_in or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else begin
			case (reg_addr_in)
				rio_pkg::REG_CONFIG:     reg_rdata_out <= {27'h000_0000, cfg};
				rio_pkg::REG_LAMPS:      reg_rdata_out <= {22'h00_0000, lamps_out};
				rio_pkg::REG_IRQ_STATUS: reg_rdata_out <= {28'h000_0000, irq_status};
				rio_pkg::REG_IRQ_MASK:   reg_rdata_out <= {28'h000_0000, irq_mask};
				rio_pkg::REG_LINK:       reg_rdata_out <= {26'h000_0000, alarm, slave_address_error_lamp_flash,
					slave_address_error_lamp_fixed, tx_error_in, term};
				default:                 reg_rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn);

	a_ready_lamp_follows: assert property (
		!(power_good_in && host_recognised_in) |=> !lamps_out.unit_ready_lamp)
		else $error("unit ready lamp lit without power or recognition");

	a_word_mode_lamps: assert property (
		power_good_in |=> lamps_out.input_single_word_lamp == $past(cfg.in_single)
		&& lamps_out.output_single_word_lamp == $past(cfg.out_single))
		else $error("word mode lamps disagree with configuration");

	a_tx_ready_error: assert property (
		tx_error_in |=> !lamps_out.tx_ready_lamp)
		else $error("transmission ready lamp lit during error");

	a_tx_lamp_error: assert property (
		power_good_in && !unit_fault_in && tx_error_in |=> lamps_out.transmitting_lamp)
		else $error("transmitting lamp not steady during error");

	a_tx_lamp_fault: assert property (
		unit_fault_in |=> !lamps_out.transmitting_lamp)
		else $error("transmitting lamp lit during unit fault");

	a_term_found_dark: assert property (
		power_good_in && term == rio_pkg::TERM_SEARCH && term_single_in && !term_multi_in
		##1 power_good_in |=> !lamps_out.terminator_lamp)
		else $error("terminator lamp still lit after single terminator");

	a_slave_address_error_lamp_fixed_on: assert property (
		power_good_in && hit_fixed ##1 power_good_in[*2] |-> lamps_out.slave_address_error_lamp)
		else $error("slave_address_error_lamp error lamp not steady for fixed address");

	a_alarm_sticky: assert property (
		slave_alarm_in |=> alarm [*8])
		else $error("slave alarm did not stay set");

	a_unit2_small_slave: assert property (
		slave_in.valid && !is_fixed_addr(slave_in.addr) && cfg.expansion && cfg.unit2
		&& slave_in.points == rio_pkg::PTS_4 && power_good_in ##1 power_good_in
		|-> slave_address_error_lamp_flash)
		else $error("small slave on second unit not flagged");

	a_clear_on_error: assert property (
		tx_error_in && !cfg.hold |=> host_in_word_out == 32'h0000_0000)
		else $error("inputs not cleared on transmission error");

	a_hold_on_error: assert property (
		tx_error_in && cfg.hold |=> $stable(host_in_word_out))
		else $error("inputs not held on transmission error");

	a_blink_phase_step: assert property (
		$changed(blink_phase) |-> $past(blink_cnt) == 23'(BLINK_HALF_CYC - 1))
		else $error("blink phase toggled off its period");

	c_multi_term: cover property (term == rio_pkg::TERM_MULTI && lamps_out.terminator_lamp);
	c_alarm_lit: cover property (lamps_out.slave_output_alarm_lamp);
	c_irq_raised: cover property (irq_out);
	c_hold_error: cover property (cfg.hold && tx_error_in ##1 tx_error_in);

endmodule : rio_ind

// ### rtl/rio_pkg.sv
package rio_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned BLINK_HALF_MS  = 250;
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int unsigned BLINK_CNT_W    = 23;

	////////////////////////////////////////////////////////////////////////////
	// register port
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [7:0] REG_CONFIG     = 8'h00;
	localparam logic [7:0] REG_LAMPS      = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
	localparam logic [7:0] REG_LINK       = 8'h10;

	localparam logic [4:0] CONFIG_RESET   = 5'h00;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// interrupt bits
	localparam int unsigned IRQ_W      = 4;
	localparam int unsigned IRQ_TXERR  = 0;
	localparam int unsigned IRQ_ALARM  = 1;
	localparam int unsigned IRQ_SLAVE_ADDRESS_ERROR_LAMP   = 2;
	localparam int unsigned IRQ_MULTI  = 3;

	////////////////////////////////////////////////////////////////////////////
	// slave addresses and sizes
	localparam logic [4:0] SLAVE_ADDRESS_ERROR_LAMP_FIXED_LO = 5'h1c;
	localparam logic [4:0] SLAVE_ADDRESS_ERROR_LAMP_FIXED_HI = 5'h1e;
	localparam logic [1:0] PTS_4         = 2'h0;
	localparam logic [1:0] PTS_8         = 2'h1;
	localparam logic [1:0] PTS_16        = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic unit2;
		logic expansion;
		logic hold;
		logic out_single;
		logic in_single;
	} rio_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] addr;
		logic [1:0] points;
		logic       other_error;
	} rio_slave_t;

	typedef struct packed {
		logic unit_ready_lamp;
		logic input_single_word_lamp;
		logic output_single_word_lamp;
		logic tx_ready_lamp;
		logic hold_lamp;
		logic transmitting_lamp;
		logic terminator_lamp;
		logic slave_address_error_lamp;
		logic slave_output_alarm_lamp;
		logic unit_number_lamp;
	} rio_lamps_t;

	typedef enum logic [1:0] {
		TERM_SEARCH = 2'h0,
		TERM_FOUND  = 2'h1,
		TERM_MULTI  = 2'h3
	} rio_term_t;

endpackage : rio_pkg

// ### sim/rio_slv_model.sv
`timescale 1ns/100ps

module rio_slv_model (
	// clock
	input  wire logic          mclk_in,
	// toward the unit
	output rio_pkg::rio_slave_t slave_out,
	output logic               alarm_out,
	output logic               word_valid_out,
	output logic [31:0]        word_out,
	output logic               term_single_out,
	output logic               term_multi_out
);
	initial begin
		slave_out = 9'h0aa;
		alarm_out = 1'h0;
		word_valid_out = 1'h0;
		word_out = 32'hffff_ffff;
		term_single_out = 1'h0;
		term_multi_out = 1'h0;
	end

	// fields left behind a report show their inverse, not stale values
	task automatic report(input logic [4:0] a, input logic [1:0] p, input logic e);
		@(posedge mclk_in);
		slave_out <= {1'h1, a, p, e};
		@(posedge mclk_in);
		slave_out <= {1'h0, ~a, ~p, ~e};
	endtask : report

	task automatic word(input logic [31:0] w);
		@(posedge mclk_in);
		word_valid_out <= 1'h1;
		word_out <= w;
		@(posedge mclk_in);
		word_valid_out <= 1'h0;
		word_out <= ~w;
	endtask : word

	// 0 alarm, 1 single terminator, 2 several terminators
	task automatic pulse(input int k);
		@(posedge mclk_in);
		{term_multi_out, term_single_out, alarm_out} <= 3'h1 << k;
		@(posedge mclk_in);
		{term_multi_out, term_single_out, alarm_out} <= 3'h0;
	endtask : pulse
endmodule : rio_slv_model

// ### sim/rio_ind_tb.sv
`timescale 1ns/100ps

module rio_ind_tb;
	logic                mclk_in;
	logic                resetn_in;
	logic [7:0]          reg_addr_in;
	logic [31:0]         reg_wdata_in;
	logic                reg_wr_in;
	logic                reg_rd_in;
	logic [31:0]         reg_rdata_out;
	logic                power_good_in;
	logic                host_recognised_in;
	logic                tx_active_in;
	logic                tx_error_in;
	logic                unit_fault_in;
	logic                term_single;
	logic                term_multi;
	rio_pkg::rio_slave_t slv;
	logic                alarm;
	logic                wvalid;
	logic [31:0]         wdata;
	logic [31:0]         host_word;
	rio_pkg::rio_lamps_t lamps;
	logic                irq_out;
	logic                rd_q;
	logic [31:0]         exp_q[$];
	logic [31:0]         msk_q[$];
	logic [4:0]          c;
	logic [4:0]          r;
	logic [31:0]         w;
	int                  fails;
	int                  samples_checked;

	rio_ind #(.BLINK_HALF_CYC(4)) i_dut (
		.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .power_good_in(power_good_in),
		.host_recognised_in(host_recognised_in), .tx_active_in(tx_active_in),
		.tx_error_in(tx_error_in), .unit_fault_in(unit_fault_in),
		.term_single_in(term_single), .term_multi_in(term_multi), .slave_in(slv),
		.slave_alarm_in(alarm), .in_word_valid_in(wvalid), .in_word_in(wdata),
		.host_in_word_out(host_word), .lamps_out(lamps), .irq_out(irq_out));

	rio_slv_model i_slv (
		.mclk_in(mclk_in), .slave_out(slv), .alarm_out(alarm), .word_valid_out(wvalid),
		.word_out(wdata), .term_single_out(term_single), .term_multi_out(term_multi));

	always #20 mclk_in = ~mclk_in;

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic summarize();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'h1;
		@(posedge mclk_in);
		reg_wr_in <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'h1;
		@(posedge mclk_in);
		reg_rd_in <= 1'h0;
	endtask : rd

	// power, host, active, error, fault
	task automatic st(input logic [4:0] v);
		@(posedge mclk_in);
		{power_good_in, host_recognised_in, tx_active_in, tx_error_in, unit_fault_in} <= v;
	endtask : st

	// result 0 dark, 1 steady, 2 blinking
	task automatic blink(input int b, input logic [1:0] e);
		logic s0;
		logic s1;
		s0 = 1'h0;
		s1 = 1'h0;
		tick(2);
		repeat (12) begin
			@(negedge mclk_in);
			s0 |= lamps[b] === 1'h0;
			s1 |= lamps[b] === 1'h1;
		end
		cmp({30'h0, s0 & s1, s1 & ~s0}, {30'h0, e});
	endtask : blink

	////////////////////////////////////////////////////////////////////////////
	// read data stand only in the cycle after the strobe
	always @(posedge mclk_in) rd_q <= reg_rd_in;

	always @(negedge mclk_in) begin
		if (rd_q) begin
			if (exp_q.size() > 0)
				cmp(reg_rdata_out & msk_q.pop_front(), exp_q.pop_front());
			else
				cmp(32'h1, 32'h0);
		end
	end

	initial begin
		tick(30000);
		fails++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_in = 1'h0;
		resetn_in = 1'h0;
		{reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
		{power_good_in, host_recognised_in, tx_active_in, tx_error_in, unit_fault_in} = '0;
		fails = 0;
		samples_checked = 0;
		rd_q = 1'h0;
		void'($urandom(79597));
		tick(3);
		cmp({22'h0, lamps}, 32'h0);
		tick(2);
		resetn_in <= 1'h1;
		tick(4);
		rd(8'h00, 32'h0, 32'hffff_ffff);
		rd(8'h0c, 32'h0, 32'hffff_ffff);
		rd(8'h20 | 8'($urandom), 32'h0, 32'hffff_ffff);
		// random configurations and unit states
		for (int i = 0; i < 12; i++) begin
			c = 5'($urandom % 32);
			r = 5'($urandom % 32);
			st(r);
			wr(8'h00, {27'h0, c});
			tick(3);
			rd(8'h00, {27'h0, c}, 32'h0000_001f);
			rd(8'h04, {22'h0, r[4] & r[3], r[4] & c[0], r[4] & c[1],
				r[4] & ~c[3] & r[2] & ~r[1], r[4] & ~c[3] & c[2], 4'h0, r[4] & c[3] & c[4]},
				c[3] ? 32'h0000_03e1 : 32'h0000_03e0);
		end
		st(5'h18);
		wr(8'h00, 32'h0);
		blink(3, 2'h1);
		blink(4, 2'h2);
		rd(8'h10, 32'h0, 32'h3);
		i_slv.pulse(1);
		blink(3, 2'h0);
		rd(8'h10, 32'h1, 32'h3);
		st(5'h1c);
		blink(4, 2'h2);
		st(5'h1e);
		blink(4, 2'h1);
		blink(6, 2'h0);
		st(5'h1f);
		blink(4, 2'h0);
		wr(8'h00, 32'h8);
		st(5'h1c);
		blink(4, 2'h2);
		st(5'h1e);
		blink(4, 2'h1);
		st(5'h1f);
		blink(4, 2'h0);
		wr(8'h00, 32'h0);
		st(5'h1c);
		i_slv.pulse(2);
		blink(3, 2'h2);
		rd(8'h10, 32'h3, 32'h3);
		repeat (12) begin
			@(negedge mclk_in);
			cmp({31'h0, lamps[3]}, {31'h0, lamps[4]});
		end
		// input words toward the host
		wr(8'h00, 32'h4);
		w = $urandom;
		i_slv.word(w);
		tick(2);
		cmp(host_word, w);
		wr(8'h00, 32'h5);
		w = $urandom;
		i_slv.word(w);
		tick(2);
		cmp(host_word, {16'h0, w[15:0]});
		st(5'h1e);
		i_slv.word(~w);
		tick(2);
		cmp(host_word, {16'h0, w[15:0]});
		wr(8'h00, 32'h1);
		tick(3);
		cmp(host_word, 32'h0);
		// slave address errors
		st(5'h00);
		tick(3);
		st(5'h1c);
		i_slv.report(5'($urandom % 28), rio_pkg::PTS_16, 1'h1);
		blink(2, 2'h2);
		i_slv.report(rio_pkg::SLAVE_ADDRESS_ERROR_LAMP_FIXED_LO, rio_pkg::PTS_16, 1'h0);
		blink(2, 2'h1);
		st(5'h00);
		tick(3);
		st(5'h1c);
		wr(8'h00, 32'h18);
		i_slv.report(5'h03, rio_pkg::PTS_4, 1'h0);
		blink(2, 2'h2);
		i_slv.report(rio_pkg::SLAVE_ADDRESS_ERROR_LAMP_FIXED_HI, rio_pkg::PTS_8, 1'h0);
		blink(2, 2'h1);
		// alarm and interrupt
		// pending: tx error edge, slave_address_error_lamp reports, several terminators
		rd(8'h08, 32'hd, 32'hffff_ffff);
		wr(8'h0c, 32'hf);
		wr(8'h08, 32'hf);
		tick(2);
		cmp({31'h0, irq_out}, 32'h0);
		i_slv.pulse(0);
		tick(3);
		rd(8'h08, 32'h2, 32'hffff_ffff);
		cmp({31'h0, irq_out}, 32'h1);
		blink(1, 2'h1);
		i_slv.pulse(0);
		rd(8'h10, 32'h20, 32'h20);
		st(5'h00);
		tick(3);
		st(5'h1c);
		blink(1, 2'h1);
		wr(8'h0c, 32'h0);
		tick(2);
		cmp({31'h0, irq_out}, 32'h0);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0, 32'hffff_ffff);
		rd(8'h0c, 32'h0, 32'hffff_ffff);
		// reset in mid-run clears configuration and link state
		tick(4);
		resetn_in <= 1'h0;
		tick(3);
		resetn_in <= 1'h1;
		tick(4);
		rd(8'h00, 32'h0, 32'hffff_ffff);
		rd(8'h10, 32'h0, 32'hffff_ffff);
		tick(4);
		summarize();
	end
endmodule : rio_ind_tb
